/* common/dbmcs_map.svh */
// register offsets, field positions, reset values and timing counts
// assumes: 5-bit register address from the serial front end, 8-bit data
`ifndef DBMCS_MAP_SVH
`define DBMCS_MAP_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define DBMCS_A_DH0 5'h00
`define DBMCS_A_DL0 5'h01
`define DBMCS_A_DH1 5'h02
`define DBMCS_A_DL1 5'h03
`define DBMCS_A_STAT 5'h04
`define DBMCS_A_CTRL0 5'h05
`define DBMCS_A_CTRL1 5'h06
`define DBMCS_A_EN 5'h07
`define DBMCS_A_POLY0 5'h08
`define DBMCS_A_POLY1 5'h09
`define DBMCS_A_SEED0 5'h0A
`define DBMCS_A_SEED1 5'h0B
`define DBMCS_A_LEN0 5'h0C
`define DBMCS_A_LEN1 5'h0D
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DBMCS_CTRL_MS 0
`define DBMCS_CTRL_TIE 2
`define DBMCS_CTRL_RIE 3
`define DBMCS_CTRL_DLY 4
`define DBMCS_CTRL_DIV 6
`define DBMCS_EN_TS 6
// ----------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------
`define DBMCS_RST_CTRL 8'h00
`define DBMCS_RST_EN 2'h0
`define DBMCS_RST_POLY 8'h11
`define DBMCS_RST_SEED 8'h0A
`define DBMCS_RST_LEN 8'h84
`define DBMCS_RST_STAT 8'h66
`define DBMCS_LONG_BITS 5'h10
`define DBMCS_CRC_MAX 4'h8
`define DBMCS_GAP_00 4'h4
`define DBMCS_GAP_01 4'h5
`define DBMCS_GAP_10 4'h6
`define DBMCS_GAP_11 4'h8
`define DBMCS_DIV_00 4'h1
`define DBMCS_DIV_01 4'h2
`define DBMCS_DIV_10 4'h4
`define DBMCS_DIV_11 4'h8
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define DBMCS_TS_CYC 16
`define DBMCS_FIFO_DEPTH 4
`endif

/* common/dbmcs_pkg.sv */
// types shared by the register bank and its helpers
// assumes: two channels, one clock domain
package dbmcs_pkg;
  // thermal filter states, one-hot
  typedef enum logic [2:0] {
    DBMCS_TH_OK = 3'b001,
    DBMCS_TH_CNT = 3'b010,
    DBMCS_TH_TRIP = 3'b100
  } dbmcs_th_e;
  typedef logic [4:0] dbmcs_cnt_t;
endpackage

/* common/dbmcs_therm_if.sv */
// thermal filter hookup between the register bank and one filter
// assumes: raw shutdown level is synchronous to clk
`timescale 1ns/1ps
interface dbmcs_therm_if;
  logic raw;
  logic rd_clr;
  logic tripped;
  logic flag;
  modport filt (input raw, input rd_clr, output tripped, output flag);
  modport user (output raw, output rd_clr, input tripped, input flag);
endinterface

/* src/dbmcs_fifo_mem.sv */
// small word store for one fifo, registered read port
// assumes: pointers are managed by the caller
`timescale 1ns/1ps
module dbmcs_fifo_mem #(
  parameter int W = 16,
  parameter int D = 4
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // sync reset, active low
  input wire logic we, // write strobe
  input wire logic [$clog2(D)-1:0] waddr, // write slot
  input wire logic [W-1:0] wdata, // write word
  input wire logic [$clog2(D)-1:0] raddr, // read slot
  output logic [W-1:0] rdata // word at raddr, one cycle late
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [W-1:0] rd;
  } dbmcs_mem_s;
  dbmcs_mem_s s_r, s_nxt;

  // store on write, always refresh the read word
  always_comb begin
    s_nxt = s_r;
    if (we) begin
      s_nxt.mem[waddr] = wdata;
    end
    s_nxt.rd = s_r.mem[raddr];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rd;
endmodule

/* src/dbmcs_thermal.sv */
// persistence filter and sticky flag for one channel's thermal sensor
// assumes: reads that clear the flag arrive as one-cycle pulses
`timescale 1ns/1ps
`include "dbmcs_map.svh"
module dbmcs_thermal
  import dbmcs_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_n, // sync reset, active low
  dbmcs_therm_if.filt tif // raw level in, filtered state out
);
  typedef struct packed {
    dbmcs_th_e st;
    dbmcs_cnt_t cnt;
    logic flag;
  } dbmcs_th_s;
  dbmcs_th_s s_r, s_nxt;

  // short glitches never reach the flag; only a full run trips
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      DBMCS_TH_OK: begin
        s_nxt.cnt = 5'h01;
        if (tif.raw) begin
          s_nxt.st = DBMCS_TH_CNT;
        end
      end
      DBMCS_TH_CNT: begin
        if (!tif.raw) begin
          s_nxt.st = DBMCS_TH_OK;
        end else if (s_r.cnt == 5'(`DBMCS_TS_CYC - 1)) begin
          s_nxt.st = DBMCS_TH_TRIP;
        end else begin
          s_nxt.cnt = s_r.cnt + 5'h01;
        end
      end
      DBMCS_TH_TRIP: begin
        if (!tif.raw) begin
          s_nxt.st = DBMCS_TH_OK;
        end
      end
      default: s_nxt.st = DBMCS_TH_OK;
    endcase
    // read clears only once the condition is gone; a new trip wins
    if (tif.rd_clr && !tif.raw) begin
      s_nxt.flag = 1'b0;
    end
    if (s_nxt.st == DBMCS_TH_TRIP) begin
      s_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '{st: DBMCS_TH_OK, cnt: 5'h00, flag: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tif.tripped = (s_r.st == DBMCS_TH_TRIP);
  assign tif.flag = s_r.flag;

  // helper: consecutive cycles of raw shutdown seen
  logic [5:0] run_r;
  always_ff @(posedge clk) begin
    if (!rst_n || !tif.raw) begin
      run_r <= 6'h00;
    end else if (run_r != 6'h3F) begin
      run_r <= run_r + 6'h01;
    end
  end

  trip_needs_run_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(tif.tripped) |-> run_r >= 6'd16) else $error("trip before 16 cycles");
  flag_held_a: assert property (@(posedge clk) disable iff (!rst_n)
    tif.flag && tif.raw |=> tif.flag) else $error("flag cleared in shutdown");
  trip_seen_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(tif.flag));
endmodule

/* src/dbmcs_top.sv */
// control and status register bank for a two-channel serial bus master
// assumes: serial front end gives decoded byte strobes, frame engine
// pops tx words and pushes rx words, shutdown sensors are synchronous
//
// Functional notes
// - interrupt low while tx empty and its enable set
// - clearing enable or writing low data byte releases tx-empty request
// - empty tx fifo takes four writes without flag checks
// - room flag reads 0 when full; writes while full are dropped
// - frame end setting both flags: rx flag first, room flag cycle later
// - rx flag 1 with data present; tx write also pops one rx entry
// - rx enable 1 ties rx flag to interrupt; 0 ignores it
// - tx enable 1 ties tx-empty flag to interrupt; 0 ignores it
// - control, polynomial, seed writes abort channel; apply after select ends, interrupt enables at once
// - gap code 00..11 gives minimum idle of 4, 5, 6, 8 bits
// - gap runs from end-of-frame fall to next frame rise
// - size bit 0 sends 16 data bits plus 0..8 crc bits
// - size bit 1 sends 8..15 data bits plus 0..8 crc bits
// - divider code 00..11 prescales bit clock by 1, 2, 4, 8
// - divider ignored while channel runs spread spectrum
// - shutdown turns off bus driver and receive detector
// - shutdown flag latches only after 16 cycles of shutdown
// - enable register read clears flags of channels out of shutdown
// - shutdown clears channel enable; host writes 1 to restart
// - polynomial bit k is x^k; bits above length ignored; top implied
// - polynomial resets to 0x11, x^4 plus 1
// - seed preloads crc, masked by length, resets to 0x0a
// - low byte write starts a transfer; high byte write alone never
// - status frozen while select low, updated after it rises
// - crc length 0..8 bits, resets to 4
`timescale 1ns/1ps
`include "dbmcs_map.svh"
module dbmcs_top
  import dbmcs_pkg::*;
#(
  parameter int DEPTH = `DBMCS_FIFO_DEPTH
) (
  input wire logic clk, // 200 MHz core clock
  input wire logic rst_n, // sync reset, active low
  input wire logic cs_n, // serial chip select, active low
  input wire logic [4:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic [7:0] reg_wdata, // write byte
  output logic [7:0] reg_rdata, // read byte, held until next read
  output logic irq_n, // interrupt, active low
  input wire logic [1:0] tx_pop, // engine takes the head tx word
  output logic [1:0][15:0] tx_word, // head tx word per channel
  output logic [1:0] tx_avail, // tx fifo holds a word
  input wire logic [1:0] rx_push, // engine delivers a word
  input wire logic [1:0][15:0] rx_data, // received word
  input wire logic [1:0] rx_crc_err, // crc error of received word
  input wire logic [1:0] therm_raw, // raw shutdown sense
  input wire logic [1:0] ss_mode, // channel in spread spectrum
  output logic [1:0] ch_on, // channel enabled
  output logic [1:0] ch_abort, // abort pulse to engine
  output logic [1:0] drv_off, // driver and detector off
  output logic [1:0][3:0] gap_bits, // minimum idle bit times
  output logic [1:0][3:0] div_n, // bit clock prescale
  output logic [1:0][4:0] word_bits, // data bits per word
  output logic [1:0][3:0] crc_len, // crc bits per word
  output logic [1:0][8:0] poly_eff, // masked polynomial, top term set
  output logic [1:0][7:0] seed_eff // masked seed
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [1:0][4:0] A_DL = {`DBMCS_A_DL1, `DBMCS_A_DL0};
  localparam logic [1:0][4:0] A_DH = {`DBMCS_A_DH1, `DBMCS_A_DH0};
  localparam logic [1:0][4:0] A_CTRL = {`DBMCS_A_CTRL1, `DBMCS_A_CTRL0};
  localparam logic [1:0][4:0] A_POLY = {`DBMCS_A_POLY1, `DBMCS_A_POLY0};
  localparam logic [1:0][4:0] A_SEED = {`DBMCS_A_SEED1, `DBMCS_A_SEED0};
  localparam logic [1:0][4:0] A_LEN = {`DBMCS_A_LEN1, `DBMCS_A_LEN0};

  typedef struct packed {
    logic [1:0][7:0] ctrl, poly, seed, len, hi;
    logic [1:0] en;
    logic [1:0][PW-1:0] twp, trp, rwp, rrp;
    logic [1:0][CW-1:0] tcnt, rcnt;
    logic [1:0] tfe, troom, rhas;
    logic [7:0] stat;
    logic [7:0] rd;
    logic irq_n;
    logic [1:0] abort;
    logic [1:0][3:0] gap, divn, clen;
    logic [1:0][4:0] wbits;
    logic [1:0][8:0] poly_q;
    logic [1:0][7:0] seed_q;
  } dbmcs_st_s;
  dbmcs_st_s s_r, s_nxt;

  logic [1:0] tx_we, rx_we, wr_dl, flush, tx_push, tx_take, rx_put, rx_take;
  logic [1:0][16:0] rx_head;
  logic [1:0] ts_flag, ts_trip;

  // ----------------------------------------------------------------------
  // thermal filters and fifo stores, one set per channel
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      dbmcs_therm_if tif ();
      assign tif.raw = therm_raw[g];
      assign tif.rd_clr = reg_rd && (reg_addr == `DBMCS_A_EN);
      assign ts_flag[g] = tif.flag;
      assign ts_trip[g] = tif.tripped;
      dbmcs_thermal u_th (
        .clk (clk),
        .rst_n (rst_n),
        .tif (tif)
      );
      dbmcs_fifo_mem #(.W(16), .D(DEPTH)) u_txm (
        .clk (clk),
        .rst_n (rst_n),
        .we (tx_we[g]),
        .waddr (s_r.twp[g]),
        .wdata ({s_r.hi[g], reg_wdata}),
        .raddr (s_r.trp[g]),
        .rdata (tx_word[g])
      );
      dbmcs_fifo_mem #(.W(17), .D(DEPTH)) u_rxm (
        .clk (clk),
        .rst_n (rst_n),
        .we (rx_we[g]),
        .waddr (s_r.rwp[g]),
        .wdata ({rx_crc_err[g], rx_data[g]}),
        .raddr (s_r.rrp[g]),
        .rdata (rx_head[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // next state: register writes, fifo bookkeeping, flags, applied setup
  // ----------------------------------------------------------------------
  always_comb begin
    logic [8:0] m;
    logic [3:0] cl;
    m = 9'h000;
    cl = 4'h0;
    s_nxt = s_r;
    s_nxt.abort = 2'b00;
    // enable bits: shutdown forces the bit low until the host rewrites it
    if (reg_wr && reg_addr == `DBMCS_A_EN) begin
      s_nxt.en = reg_wdata[1:0];
    end
    s_nxt.en = s_nxt.en & ~ts_trip;
    for (int c = 0; c < 2; c++) begin
      wr_dl[c] = reg_wr && reg_addr == A_DL[c];
      flush[c] = (reg_wr && (reg_addr == A_CTRL[c] || reg_addr == A_POLY[c] ||
                  reg_addr == A_SEED[c] || reg_addr == A_LEN[c])) ||
                 (s_r.en[c] && !s_nxt.en[c]);
      tx_push[c] = wr_dl[c] && s_r.tcnt[c] != FULL;
      tx_take[c] = tx_pop[c] && s_r.tcnt[c] != '0;
      rx_put[c] = rx_push[c] && s_r.rcnt[c] != FULL;
      rx_take[c] = wr_dl[c] && s_r.rcnt[c] != '0;
      tx_we[c] = tx_push[c] && !flush[c];
      rx_we[c] = rx_put[c] && !flush[c];
      s_nxt.abort[c] = flush[c];
      if (reg_wr && reg_addr == A_DH[c]) begin
        s_nxt.hi[c] = reg_wdata; // held only; no transfer starts
      end
      if (reg_wr && reg_addr == A_CTRL[c]) begin
        s_nxt.ctrl[c] = {reg_wdata[7:2], 1'b0, reg_wdata[0]};
      end
      if (reg_wr && reg_addr == A_POLY[c]) begin
        s_nxt.poly[c] = reg_wdata;
      end
      if (reg_wr && reg_addr == A_SEED[c]) begin
        s_nxt.seed[c] = reg_wdata;
      end
      if (reg_wr && reg_addr == A_LEN[c]) begin
        // short length never below 8; crc length clamps at 8
        s_nxt.len[c][7:4] = {1'b1, reg_wdata[6:4]};
        s_nxt.len[c][3:0] = (reg_wdata[3:0] > `DBMCS_CRC_MAX) ?
                            `DBMCS_CRC_MAX : reg_wdata[3:0];
      end
      // fifo pointers and counts; four slots fill back to back
      if (flush[c]) begin
        s_nxt.twp[c] = '0;
        s_nxt.trp[c] = '0;
        s_nxt.rwp[c] = '0;
        s_nxt.rrp[c] = '0;
        s_nxt.tcnt[c] = '0;
        s_nxt.rcnt[c] = '0;
      end else begin
        s_nxt.twp[c] = s_r.twp[c] + PW'(tx_push[c]);
        s_nxt.trp[c] = s_r.trp[c] + PW'(tx_take[c]);
        s_nxt.rwp[c] = s_r.rwp[c] + PW'(rx_put[c]);
        s_nxt.rrp[c] = s_r.rrp[c] + PW'(rx_take[c]);
        s_nxt.tcnt[c] = s_r.tcnt[c] + CW'(tx_push[c]) - CW'(tx_take[c]);
        s_nxt.rcnt[c] = s_r.rcnt[c] + CW'(rx_put[c]) - CW'(rx_take[c]);
      end
      s_nxt.tfe[c] = s_nxt.tcnt[c] == '0;
      s_nxt.rhas[c] = s_nxt.rcnt[c] != '0;
      // room flag drops with the count but rises a cycle late, so rx flag leads it
      s_nxt.troom[c] = flush[c] || (s_nxt.tcnt[c] != FULL && s_r.tcnt[c] != FULL);
      // setup reaches the engine only once the select has ended
      if (cs_n) begin
        case (s_r.ctrl[c][`DBMCS_CTRL_DLY +: 2])
          2'b00: s_nxt.gap[c] = `DBMCS_GAP_00;
          2'b01: s_nxt.gap[c] = `DBMCS_GAP_01;
          2'b10: s_nxt.gap[c] = `DBMCS_GAP_10;
          default: s_nxt.gap[c] = `DBMCS_GAP_11;
        endcase
        case (s_r.ctrl[c][`DBMCS_CTRL_DIV +: 2])
          2'b00: s_nxt.divn[c] = `DBMCS_DIV_00;
          2'b01: s_nxt.divn[c] = `DBMCS_DIV_01;
          2'b10: s_nxt.divn[c] = `DBMCS_DIV_10;
          default: s_nxt.divn[c] = `DBMCS_DIV_11;
        endcase
        if (ss_mode[c]) begin
          s_nxt.divn[c] = `DBMCS_DIV_00;
        end
        s_nxt.wbits[c] = s_r.ctrl[c][`DBMCS_CTRL_MS] ?
                         {1'b0, s_r.len[c][7:4]} : `DBMCS_LONG_BITS;
        cl = s_r.len[c][3:0];
        m = (9'h001 << cl) - 9'h001;
        s_nxt.clen[c] = cl;
        s_nxt.poly_q[c] = ({1'b0, s_r.poly[c]} & m) | (9'h001 << cl);
        s_nxt.seed_q[c] = s_r.seed[c] & m[7:0];
      end
    end
    // status snapshot only while deselected
    if (cs_n) begin
      s_nxt.stat = {s_r.rhas[1] & rx_head[1][16], s_r.tfe[1], s_r.troom[1], s_r.rhas[1],
                    s_r.rhas[0] & rx_head[0][16], s_r.tfe[0], s_r.troom[0], s_r.rhas[0]};
    end
    // interrupt: or of enabled requests, low when any is up
    s_nxt.irq_n = ~|((s_r.tfe & {s_r.ctrl[1][`DBMCS_CTRL_TIE], s_r.ctrl[0][`DBMCS_CTRL_TIE]}) |
                     (s_r.rhas & {s_r.ctrl[1][`DBMCS_CTRL_RIE], s_r.ctrl[0][`DBMCS_CTRL_RIE]}));
    if (reg_rd) begin
      case (reg_addr)
        `DBMCS_A_DH0: s_nxt.rd = rx_head[0][15:8];
        `DBMCS_A_DL0: s_nxt.rd = rx_head[0][7:0];
        `DBMCS_A_DH1: s_nxt.rd = rx_head[1][15:8];
        `DBMCS_A_DL1: s_nxt.rd = rx_head[1][7:0];
        `DBMCS_A_STAT: s_nxt.rd = s_r.stat;
        `DBMCS_A_CTRL0: s_nxt.rd = s_r.ctrl[0];
        `DBMCS_A_CTRL1: s_nxt.rd = s_r.ctrl[1];
        `DBMCS_A_EN: s_nxt.rd = {ts_flag, 4'h0, s_r.en};
        `DBMCS_A_POLY0: s_nxt.rd = s_r.poly[0];
        `DBMCS_A_POLY1: s_nxt.rd = s_r.poly[1];
        `DBMCS_A_SEED0: s_nxt.rd = s_r.seed[0];
        `DBMCS_A_SEED1: s_nxt.rd = s_r.seed[1];
        `DBMCS_A_LEN0: s_nxt.rd = s_r.len[0];
        `DBMCS_A_LEN1: s_nxt.rd = s_r.len[1];
        default: s_nxt.rd = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.ctrl <= {2{`DBMCS_RST_CTRL}};
      s_r.poly <= {2{`DBMCS_RST_POLY}};
      s_r.seed <= {2{`DBMCS_RST_SEED}};
      s_r.len <= {2{`DBMCS_RST_LEN}};
      s_r.en <= `DBMCS_RST_EN;
      s_r.tfe <= 2'b11;
      s_r.troom <= 2'b11;
      s_r.stat <= `DBMCS_RST_STAT;
      s_r.irq_n <= 1'b1;
      s_r.gap <= {2{`DBMCS_GAP_00}};
      s_r.divn <= {2{`DBMCS_DIV_00}};
      s_r.wbits <= {2{`DBMCS_LONG_BITS}};
      s_r.clen <= {2{4'h4}};
      s_r.poly_q <= {2{9'h011}};
      s_r.seed_q <= {2{8'h0A}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------------
  assign reg_rdata = s_r.rd;
  assign irq_n = s_r.irq_n;
  assign tx_avail = ~s_r.tfe;
  assign ch_on = s_r.en;
  assign ch_abort = s_r.abort;
  assign drv_off = ts_trip;
  assign gap_bits = s_r.gap; // engine counts fall-to-rise
  assign div_n = s_r.divn;
  assign word_bits = s_r.wbits;
  assign crc_len = s_r.clen;
  assign poly_eff = s_r.poly_q;
  assign seed_eff = s_r.seed_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  irq_tx_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.tfe[0] && s_r.ctrl[0][`DBMCS_CTRL_TIE] |=> !irq_n) else $error("tx irq missing");
  irq_rx_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.rhas[1] && s_r.ctrl[1][`DBMCS_CTRL_RIE] |=> !irq_n) else $error("rx irq missing");
  irq_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(|(s_r.tfe & {s_r.ctrl[1][2], s_r.ctrl[0][2]})) &&
    !(|(s_r.rhas & {s_r.ctrl[1][3], s_r.ctrl[0][3]})) |=> irq_n)
    else $error("irq without cause");
  full_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_dl[0] && s_r.tcnt[0] == FULL && !tx_pop[0] && !flush[0] |=> s_r.tcnt[0] == FULL)
    else $error("write accepted while full");
  room_lag_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.tcnt[0] == FULL && tx_take[0] && !wr_dl[0] && !flush[0] |=> !s_r.troom[0] ##1 s_r.troom[0])
    else $error("room flag timing");
  rx_pop_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_take[0] && !rx_put[0] && !flush[0] |=> s_r.rcnt[0] == $past(s_r.rcnt[0]) - CW'(1))
    else $error("rx not popped");
  stat_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !cs_n && !$past(cs_n) |-> $stable(s_r.stat)) else $error("status moved in select");
  cfg_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && reg_addr == `DBMCS_A_POLY1 |=> ch_abort[1] && s_r.tcnt[1] == '0)
    else $error("no abort on write");
  trip_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    ts_trip[0] |=> !ch_on[0]) else $error("channel on in shutdown");
  fill_four_c: cover property (@(posedge clk) disable iff (!rst_n) s_r.tcnt[0] == FULL);
  rx_both_c: cover property (@(posedge clk) disable iff (!rst_n) rx_put[1] && tx_take[1]);
  abort_c: cover property (@(posedge clk) disable iff (!rst_n) ch_abort[0]);
endmodule

/* test/dbmcs_engine_model.sv */
// frame engine stand-in: takes tx words, returns inverted words a frame later
// assumes: driven from the register bank ports, one clock
`timescale 1ns/1ps
module dbmcs_engine_model #(
  parameter int FRAME = 8
) (
  input wire logic clk, // core clock
  input wire logic [1:0] tx_avail, // word waiting
  input wire logic [1:0][15:0] tx_word, // head word
  input wire logic [1:0] ch_on, // channel on
  input wire logic [1:0] drv_off, // driver off
  output logic [1:0] tx_pop, // take word
  output logic [1:0] rx_push, // deliver word
  output logic [1:0][15:0] rx_data, // received word
  output logic [1:0] rx_crc_err, // crc status
  output int pops // channel 0 words taken
);
  int t [2] = '{0, 0};
  logic [1:0][15:0] w;
  initial begin
    tx_pop = '0;
    rx_push = '0;
    rx_data = '0;
    rx_crc_err = '0;
    pops = 0;
  end
  // one word per frame; idle data toggles so stale values never look valid
  always @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      tx_pop[c] <= 1'b0;
      rx_push[c] <= 1'b0;
      rx_data[c] <= ~rx_data[c];
      if (t[c] == 0 && tx_avail[c] && ch_on[c] && !tx_pop[c]) begin
        tx_pop[c] <= 1'b1;
        w[c] <= tx_word[c];
        t[c] <= FRAME;
        if (c == 0) pops <= pops + 1;
      end else if (t[c] == 1) begin
        rx_push[c] <= 1'b1;
        rx_data[c] <= drv_off[c] ? 16'h0000 : ~w[c];
        rx_crc_err[c] <= drv_off[c];
        t[c] <= 0;
      end else if (t[c] > 1) begin
        t[c] <= t[c] - 1;
      end
    end
  end
endmodule

/* test/test_dual_bus_master_ctrl_status.sv */
// self-checking bench for the register bank with an engine stand-in
// assumes: select stays high outside the hold check, so status follows the fifos
`timescale 1ns/1ps
`include "dbmcs_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module test_dual_bus_master_ctrl_status;
  logic clk = 0, rst_n = 0, cs_n = 1, reg_wr = 0, reg_rd = 0, irq_n, ab_seen = 0;
  logic [4:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, v;
  logic [1:0] tx_pop, tx_avail, rx_push, rx_crc_err, ch_on, ch_abort, drv_off;
  logic [1:0] therm_raw = 0, ss_mode = 0;
  logic [1:0][15:0] tx_word, rx_data;
  logic [1:0][3:0] gap_bits, div_n, crc_len;
  logic [1:0][4:0] word_bits;
  logic [1:0][8:0] poly_eff;
  logic [1:0][7:0] seed_eff;
  int num_errors = 0, checks_done = 0, cyc = 0, pops;
  localparam logic [12:0] ROWS [7] = '{{5'h04, 8'h66}, {5'h05, 8'h00}, {5'h07, 8'h00},
    {5'h08, 8'h11}, {5'h0B, 8'h0A}, {5'h0C, 8'h84}, {5'h1F, 8'h00}};
  localparam logic [3:0] GAP [4] = '{4'h4, 4'h5, 4'h6, 4'h8};
  dbmcs_top u_dbmcs_top (.clk, .rst_n, .cs_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .irq_n, .tx_pop, .tx_word, .tx_avail, .rx_push, .rx_data, .rx_crc_err,
    .therm_raw, .ss_mode, .ch_on, .ch_abort, .drv_off, .gap_bits, .div_n, .word_bits,
    .crc_len, .poly_eff, .seed_eff);
  dbmcs_engine_model u_dbmcs_engine_model (.clk, .tx_avail, .tx_word, .ch_on, .drv_off,
    .tx_pop, .rx_push, .rx_data, .rx_crc_err, .pops);
  always #2.5 clk = ~clk;
  // channel 1 abort pulses last one cycle, so latch them for later checking
  always @(posedge clk) if (ch_abort[1]) ab_seen <= 1'b1;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    wt(5);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      rd(ROWS[i][12:8]);
      `CHK(v, ROWS[i][7:0])
    end
    `CHK({poly_eff[0], seed_eff[0]}, {9'h011, 8'h0A})
    `CHK({word_bits[0], crc_len[0]}, {5'h10, 4'h4})
    wr(`DBMCS_A_CTRL1, 8'h04);
    wt(4); `CHK(irq_n, 1'b0)
    wr(`DBMCS_A_DH1, 8'h55);
    wt(4); `CHK(irq_n, 1'b0)
    wr(`DBMCS_A_DL1, 8'h66);
    wt(4); `CHK(irq_n, 1'b1)
    wr(`DBMCS_A_CTRL0, 8'h08);
    wt(4); `CHK(irq_n, 1'b1)
    for (int i = 0; i < 5; i++) begin
      wr(`DBMCS_A_DH0, 8'h10 + 8'(i));
      wr(`DBMCS_A_DL0, 8'h20 + 8'(i));
      if (i == 3) rd(`DBMCS_A_STAT);
      if (i == 3) `CHK(v, 8'h20)
    end
    wr(`DBMCS_A_EN, 8'h01);
    wt(60); `CHK(pops, 4)
    rd(`DBMCS_A_STAT); `CHK(v, 8'h27)
    `CHK(irq_n, 1'b0)
    rd(`DBMCS_A_DL0); `CHK(v, 8'hDF)
    wr(`DBMCS_A_DL0, 8'h33);
    rd(`DBMCS_A_DL0); `CHK(v, 8'hDE)
    for (int c = 0; c < 4; c++) begin
      wr(`DBMCS_A_CTRL1, {c[1:0], c[1:0], 4'h1});
      wt(3); `CHK(gap_bits[1], GAP[c])
      `CHK(div_n[1], 4'h1 << c)
    end
    `CHK(word_bits[1], 5'h08)
    ss_mode[1] <= 1'b1;
    wt(3); `CHK(div_n[1], 4'h1)
    ss_mode[1] <= 1'b0;
    ab_seen = 1'b0;
    wr(`DBMCS_A_POLY1, 8'hC9);
    wt(3); `CHK(ab_seen, 1'b1)
    wr(`DBMCS_A_LEN1, 8'h86);
    wr(`DBMCS_A_SEED1, 8'hD5);
    wt(3); `CHK(poly_eff[1], 9'h049)
    `CHK(seed_eff[1], 8'h15)
    wr(`DBMCS_A_EN, 8'h03);
    therm_raw[1] <= 1'b1;
    wt(15);
    therm_raw[1] <= 1'b0;
    wt(3); `CHK(drv_off[1], 1'b0)
    therm_raw[1] <= 1'b1;
    wt(20); `CHK(drv_off[1], 1'b1)
    `CHK(ch_on, 2'b01)
    rd(`DBMCS_A_EN); `CHK(v, 8'h81)
    rd(`DBMCS_A_EN); `CHK(v, 8'h81)
    therm_raw[1] <= 1'b0;
    wt(3); rd(`DBMCS_A_EN);
    rd(`DBMCS_A_EN); `CHK(v, 8'h01)
    wr(`DBMCS_A_EN, 8'h03);
    wt(3); `CHK(ch_on, 2'b11)
    // select low: status snapshot and applied setup must both hold still
    cs_n <= 1'b0;
    wr(`DBMCS_A_CTRL1, 8'h01);
    wr(`DBMCS_A_DL1, 8'h5A);
    wt(3); `CHK(gap_bits[1], 4'h8)
    rd(`DBMCS_A_STAT); `CHK(v, 8'h67)
    cs_n <= 1'b1;
    wt(3); `CHK(gap_bits[1], 4'h4)
    wt(12); rd(`DBMCS_A_STAT); `CHK(v, 8'h77)
    // crc length above 8 clamps, short length top bit is forced to 1
    wr(`DBMCS_A_LEN1, 8'h2F);
    wt(3); `CHK(crc_len[1], 4'h8)
    `CHK(word_bits[1], 5'h0A)
    rd(`DBMCS_A_LEN1); `CHK(v, 8'hA8)
    final_report();
  end
endmodule
